// file: rtl/tdd_top.sv
// transmit command descriptor decoder: ring walk, buffer fetch, tag insertion, write-back
`timescale 1ns/10ps
`include "tdd_map.svh"

module tdd_top #(
    parameter int IDX_W = 8
) (
    input  wire logic                 CLK_I,
    input  wire logic                 RST_N_I,
    input  wire logic                 POLL_I,
    output logic                      FETCH_REQ_O,
    output logic [IDX_W-1:0]          FETCH_IDX_O,
    input  wire logic                 FETCH_VALID_I,
    input  wire tdd_pkg::tdd_desc_t   FETCH_DESC_I,
    output logic                      BUF_REQ_O,
    output logic [63:0]               BUF_ADDR_O,
    output logic [15:0]               BUF_LEN_O,
    input  wire logic                 BUF_VALID_I,
    input  wire logic [7:0]           BUF_DATA_I,
    output logic                      BUF_READY_O,
    output logic                      TX_VALID_O,
    output logic [7:0]                TX_DATA_O,
    output logic                      TX_SOF_O,
    output logic                      TX_EOF_O,
    input  wire logic                 TX_READY_I,
    output tdd_pkg::tdd_offload_t     OFFLOAD_O,
    output logic                      WB_REQ_O,
    output logic [IDX_W-1:0]          WB_IDX_O,
    output logic [31:0]               WB_WORD0_O,
    input  wire logic                 WB_ACK_I
);
    import tdd_pkg::*;

    // ============================================================
    // declarations
    tdd_state_t       state;
    tdd_state_t       next_state;
    logic [IDX_W-1:0] ring_idx;
    logic [31:0]      cmd_word;
    logic [15:0]      tag_info;
    logic             tag_on;
    logic [15:0]      seg_left;
    logic [15:0]      frame_pos;
    logic [2:0]       ins_cnt;
    logic             slot_free;
    logic             ins_now;
    logic             take_buf;
    logic             load_tx;
    logic             seg_done;
    logic [7:0]       ins_byte;
    logic [7:0]       next_byte;
    logic             own_ok;

    assign own_ok    = FETCH_DESC_I.cmd_word[`TDD_OWN_BIT];
    assign slot_free = !TX_VALID_O || TX_READY_I;
    // tag goes in before the first byte that follows the source address
    assign ins_now   = (state == TDD_XFER) && tag_on && (frame_pos == `TDD_TAG_POS) &&
                       (ins_cnt != `TDD_TAG_BYTES) && (seg_left != `TDD_RST_LEN);
    assign take_buf  = BUF_READY_O && BUF_VALID_I;
    assign load_tx   = (ins_now && slot_free && !take_buf) || take_buf;
    assign seg_done  = (seg_left == `TDD_RST_LEN) && !BUF_READY_O && slot_free;

    // ============================================================
    // inserted bytes: protocol id high byte first, then tag low byte first
    always_comb begin
        case (ins_cnt)
            3'h0:    ins_byte = 8'(`TDD_TPID >> 8);
            3'h1:    ins_byte = 8'(`TDD_TPID);
            3'h2:    ins_byte = tag_info[7:0];
            default: ins_byte = tag_info[`TDD_TAG_MSB:`TDD_VID_LOW_LSB];
        endcase
    end

    always_comb begin
        next_byte = take_buf ? BUF_DATA_I : ins_byte;
    end

    // ============================================================
    // sequencer
    always_comb begin
        next_state = state;
        case (state)
            TDD_IDLE: begin
                if (POLL_I) begin
                    next_state = TDD_FETCH;
                end
            end
            TDD_FETCH: begin
                if (FETCH_VALID_I) begin
                    next_state = own_ok ? TDD_XFER : TDD_IDLE;
                end
            end
            TDD_XFER: begin
                if (seg_done && !BUF_REQ_O) begin
                    next_state = TDD_WBACK;
                end
            end
            TDD_WBACK: begin
                if (WB_ACK_I) begin
                    next_state = TDD_FETCH;
                end
            end
            default: begin
                next_state = TDD_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            state <= TDD_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ============================================================
    // ring pointer
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            ring_idx <= '0;
        end else if (state == TDD_WBACK && WB_ACK_I) begin
            if (cmd_word[`TDD_RING_END_BIT]) begin
                ring_idx <= '0;
            end else begin
                ring_idx <= ring_idx + 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            FETCH_REQ_O <= 1'b0;
            FETCH_IDX_O <= '0;
        end else begin
            FETCH_REQ_O <= (next_state == TDD_FETCH);
            FETCH_IDX_O <= (state == TDD_WBACK && WB_ACK_I && cmd_word[`TDD_RING_END_BIT]) ? '0 :
                           (state == TDD_WBACK && WB_ACK_I) ? ring_idx + 1'b1 : ring_idx;
        end
    end

    // ============================================================
    // descriptor capture; reserved bits and bit 27 are never looked at
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            cmd_word   <= '0;
            BUF_REQ_O  <= 1'b0;
            BUF_ADDR_O <= '0;
            BUF_LEN_O  <= `TDD_RST_LEN;
        end else if (state == TDD_FETCH && FETCH_VALID_I && own_ok) begin
            cmd_word   <= FETCH_DESC_I.cmd_word;
            BUF_REQ_O  <= 1'b1;
            BUF_ADDR_O <= {FETCH_DESC_I.addr_high, FETCH_DESC_I.addr_low};
            BUF_LEN_O  <= FETCH_DESC_I.cmd_word[`TDD_LEN_MSB:0];
        end else begin
            BUF_REQ_O  <= 1'b0;
        end
    end

    // frame-wide settings come only from the first segment
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            tag_on    <= 1'b0;
            tag_info  <= '0;
            OFFLOAD_O <= '0;
        end else if (state == TDD_FETCH && FETCH_VALID_I && own_ok &&
                     FETCH_DESC_I.cmd_word[`TDD_FIRST_BIT]) begin
            tag_on    <= FETCH_DESC_I.tag_word[`TDD_TAG_EN_BIT];
            tag_info  <= FETCH_DESC_I.tag_word[`TDD_TAG_MSB:0];
            OFFLOAD_O.ip_checksum_request  <= FETCH_DESC_I.cmd_word[`TDD_IP_CS_BIT];
            OFFLOAD_O.udp_checksum_request <= FETCH_DESC_I.cmd_word[`TDD_UDP_CS_BIT];
            OFFLOAD_O.tcp_checksum_request <= FETCH_DESC_I.cmd_word[`TDD_TCP_CS_BIT];
        end
    end

    // ============================================================
    // byte counters
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            seg_left <= `TDD_RST_LEN;
        end else if (state == TDD_FETCH && FETCH_VALID_I && own_ok) begin
            seg_left <= FETCH_DESC_I.cmd_word[`TDD_LEN_MSB:0];
        end else if (take_buf) begin
            seg_left <= seg_left - 1'b1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            frame_pos <= `TDD_RST_LEN;
            ins_cnt   <= '0;
        end else if (state == TDD_FETCH && FETCH_VALID_I && own_ok &&
                     FETCH_DESC_I.cmd_word[`TDD_FIRST_BIT]) begin
            frame_pos <= `TDD_RST_LEN;
            ins_cnt   <= '0;
        end else if (load_tx && !take_buf) begin
            ins_cnt   <= ins_cnt + 1'b1;
        end else if (take_buf) begin
            frame_pos <= frame_pos + 1'b1;
        end
    end

    // buffer is pulled one byte at a time into an empty output slot
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            BUF_READY_O <= 1'b0;
        end else begin
            BUF_READY_O <= (state == TDD_XFER) && !BUF_REQ_O && !load_tx && slot_free &&
                           !ins_now && !BUF_READY_O && (seg_left != `TDD_RST_LEN);
        end
    end

    // ============================================================
    // transmit byte stream
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            TX_VALID_O <= 1'b0;
            TX_DATA_O  <= `TDD_RST_BYTE;
            TX_SOF_O   <= 1'b0;
            TX_EOF_O   <= 1'b0;
        end else if (load_tx) begin
            TX_VALID_O <= 1'b1;
            TX_DATA_O  <= next_byte;
            TX_SOF_O   <= take_buf && cmd_word[`TDD_FIRST_BIT] && (frame_pos == `TDD_RST_LEN);
            TX_EOF_O   <= take_buf && cmd_word[`TDD_LAST_BIT] && (seg_left == 16'h0001);
        end else if (TX_READY_I) begin
            TX_VALID_O <= 1'b0;
            TX_SOF_O   <= 1'b0;
            TX_EOF_O   <= 1'b0;
        end
    end

    // ============================================================
    // status write-back: ownership back to the host, ring end, first and last flags kept
    always_ff @(posedge CLK_I) begin
        if (!RST_N_I) begin
            WB_REQ_O   <= 1'b0;
            WB_IDX_O   <= '0;
            WB_WORD0_O <= '0;
        end else if (next_state == TDD_WBACK) begin
            WB_REQ_O   <= 1'b1;
            WB_IDX_O   <= ring_idx;
            WB_WORD0_O <= cmd_word & `TDD_FLAG_MASK;
        end else begin
            WB_REQ_O   <= 1'b0;
        end
    end

endmodule // tdd_top

// file: rtl/tdd_map.svh
// constants for the transmit command descriptor decoder
`ifndef TDD_MAP_SVH
`define TDD_MAP_SVH

// ============================================================
// descriptor layout
`define TDD_OFS_CMD        8'h00
`define TDD_OFS_TAG        8'h04
`define TDD_OFS_ADDR_LOW   8'h08
`define TDD_OFS_ADDR_HIGH  8'h0c
`define TDD_OWN_BIT        31
`define TDD_RING_END_BIT   30
`define TDD_FIRST_BIT      29
`define TDD_LAST_BIT       28
`define TDD_SEG_OFF_BIT    27
`define TDD_IP_CS_BIT      18
`define TDD_UDP_CS_BIT     17
`define TDD_TCP_CS_BIT     16
`define TDD_LEN_MSB        15
`define TDD_TAG_EN_BIT     17
`define TDD_TAG_MSB        15
`define TDD_VID_LOW_LSB    8
`define TDD_VID_HIGH_MSB   3
`define TDD_FLAG_MASK      32'h7000_0000

// ============================================================
// tag insertion
`define TDD_TPID           16'h8100
`define TDD_TAG_POS        16'h000c
`define TDD_TAG_BYTES      3'h4

// ============================================================
// reset values
`define TDD_RST_BYTE       8'h00
`define TDD_RST_LEN        16'h0000

`endif

// file: rtl/tdd_pkg.sv
// types for the transmit command descriptor decoder
package tdd_pkg;

    // ============================================================
    // descriptor as fetched: four words, word 0 lowest
    typedef struct packed {
        logic [31:0] addr_high;
        logic [31:0] addr_low;
        logic [31:0] tag_word;
        logic [31:0] cmd_word;
    } tdd_desc_t;

    // ============================================================
    // per-frame checksum offload requests
    typedef struct packed {
        logic ip_checksum_request;
        logic udp_checksum_request;
        logic tcp_checksum_request;
    } tdd_offload_t;

    // ============================================================
    // sequencer states, gray along idle-fetch-xfer-writeback
    typedef enum logic [1:0] {
        TDD_IDLE  = 2'b00,
        TDD_FETCH = 2'b01,
        TDD_XFER  = 2'b11,
        TDD_WBACK = 2'b10
    } tdd_state_t;

endpackage

// file: test/tdd_top_properties.sv
// port assertions for the transmit descriptor decoder
`timescale 1ns/10ps

module tdd_chk #(
    parameter int IDX_W = 8
) (
    input wire logic             CLK_I,
    input wire logic             RST_N_I,
    input wire logic             FETCH_REQ_O,
    input wire logic [IDX_W-1:0] FETCH_IDX_O,
    input wire logic             FETCH_VALID_I,
    input wire tdd_pkg::tdd_desc_t FETCH_DESC_I,
    input wire logic             BUF_REQ_O,
    input wire logic [63:0]      BUF_ADDR_O,
    input wire logic [15:0]      BUF_LEN_O,
    input wire logic             BUF_VALID_I,
    input wire logic [7:0]       BUF_DATA_I,
    input wire logic             BUF_READY_O,
    input wire logic             TX_VALID_O,
    input wire logic [7:0]       TX_DATA_O,
    input wire logic             TX_READY_I,
    input wire logic             WB_REQ_O,
    input wire logic [IDX_W-1:0] WB_IDX_O,
    input wire logic [31:0]      WB_WORD0_O,
    input wire logic             WB_ACK_I
);
    import tdd_pkg::*;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    logic take;
    assign take = FETCH_REQ_O && FETCH_VALID_I;
    property p_buf; take && FETCH_DESC_I.cmd_word[31] && FETCH_DESC_I.cmd_word[15:0] != 16'h0000 |=> BUF_REQ_O
        && BUF_LEN_O == $past(FETCH_DESC_I.cmd_word[15:0]) && BUF_ADDR_O == $past({FETCH_DESC_I.addr_high,
        FETCH_DESC_I.addr_low}); endproperty
    a_buf: assert property (p_buf) else $error("buffer request off");
    property p_own; take && !FETCH_DESC_I.cmd_word[31] |=> !BUF_REQ_O && !WB_REQ_O; endproperty
    a_own: assert property (p_own) else $error("host owned sent");
    property p_wbw; WB_REQ_O |-> !WB_WORD0_O[31] && WB_WORD0_O[27:0] == 28'h0000000; endproperty
    a_wbw: assert property (p_wbw) else $error("status word off");
    property p_wrap; WB_ACK_I && WB_WORD0_O[30] |=> FETCH_REQ_O && FETCH_IDX_O == '0; endproperty
    a_wrap: assert property (p_wrap) else $error("no ring wrap");
    property p_step; WB_ACK_I && !WB_WORD0_O[30] |=> FETCH_REQ_O && FETCH_IDX_O == IDX_W'($past(WB_IDX_O) + 1'h1);
    endproperty
    a_step: assert property (p_step) else $error("index step off");
    property p_gap; BUF_READY_O |=> !BUF_READY_O; endproperty
    a_gap: assert property (p_gap) else $error("ready too close");
    property p_pass; BUF_VALID_I && BUF_READY_O |=> TX_VALID_O && TX_DATA_O == $past(BUF_DATA_I); endproperty
    a_pass: assert property (p_pass) else $error("byte not passed");
    property p_hold; TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O); endproperty
    a_hold: assert property (p_hold) else $error("byte dropped");
endmodule // tdd_chk

bind tdd_top tdd_chk #(.IDX_W(IDX_W)) u_tdd_chk (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .FETCH_REQ_O(FETCH_REQ_O), .FETCH_IDX_O(FETCH_IDX_O),
    .FETCH_VALID_I(FETCH_VALID_I), .FETCH_DESC_I(FETCH_DESC_I), .BUF_REQ_O(BUF_REQ_O), .BUF_ADDR_O(BUF_ADDR_O),
    .BUF_LEN_O(BUF_LEN_O), .BUF_VALID_I(BUF_VALID_I), .BUF_DATA_I(BUF_DATA_I), .BUF_READY_O(BUF_READY_O),
    .TX_VALID_O(TX_VALID_O), .TX_DATA_O(TX_DATA_O), .TX_READY_I(TX_READY_I), .WB_REQ_O(WB_REQ_O),
    .WB_IDX_O(WB_IDX_O), .WB_WORD0_O(WB_WORD0_O), .WB_ACK_I(WB_ACK_I));

// file: test/tdd_host.sv
// host memory model: descriptor ring, buffer bytes, write-back acknowledge
`timescale 1ns/10ps

module tdd_host (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         fetch_req_i,
    input  wire logic [7:0]   fetch_idx_i,
    output tdd_pkg::tdd_desc_t fetch_desc_o,
    output logic              fetch_valid_o,
    input  wire logic         buf_req_i,
    input  wire logic [63:0]  buf_addr_i,
    input  wire logic [15:0]  buf_len_i,
    input  wire logic         buf_ready_i,
    output logic              buf_valid_o,
    output logic [7:0]        buf_data_o,
    input  wire logic         wb_req_i,
    input  wire logic [7:0]   wb_idx_i,
    input  wire logic [31:0]  wb_word_i,
    output logic              wb_ack_o
);
    import tdd_pkg::*;
    tdd_desc_t   ring [0:7];
    logic [31:0] wb_seen [0:7];
    int          slow = 0, wait_f = 0, cyc = 0;
    logic        f, b, taken = 1'h0, wb_pend = 1'h0;
    logic [7:0]  base, sent;
    logic [15:0] left;
    initial begin
        fetch_desc_o = '0;
        fetch_valid_o = 1'h0;
        buf_valid_o = 1'h0;
        buf_data_o = 8'h00;
        wb_ack_o = 1'h0;
    end
    // bytes counted at the edge where the decoder takes them
    always @(posedge clk_i) begin
        taken <= buf_valid_o && buf_ready_i;
        if (!rst_n_i || buf_req_i) begin
            base <= buf_addr_i[7:0];
            sent <= 8'h00;
            left <= rst_n_i ? buf_len_i : 16'h0000;
        end else if (buf_valid_o && buf_ready_i) begin
            sent <= sent + 8'h01;
            left <= left - 16'h0001;
        end
    end
    // idle lines toggle so a stale value is never mistaken for data
    always @(negedge clk_i) begin
        f = rst_n_i && fetch_req_i && !fetch_valid_o && wait_f >= slow;
        // a byte on offer stays until the decoder has taken it
        b = left != 16'h0000 && ((buf_valid_o && !taken) || cyc % (slow + 1) == 0);
        cyc <= cyc + 1;
        wait_f <= f || !fetch_req_i ? 0 : wait_f + 1;
        fetch_valid_o <= f;
        fetch_desc_o <= f ? ring[fetch_idx_i[2:0]] : ~fetch_desc_o;
        buf_valid_o <= b;
        buf_data_o <= b ? base + sent : ~buf_data_o;
        wb_pend <= wb_req_i;
        // one-cycle acknowledge, a cycle after the request is seen
        wb_ack_o <= wb_req_i && wb_pend && !wb_ack_o;
        // status lands in the ring, so a later lap finds the slot host-owned
        if (wb_req_i) begin
            wb_seen[wb_idx_i[2:0]] <= wb_word_i;
            ring[wb_idx_i[2:0]].cmd_word <= wb_word_i;
        end
    end
endmodule // tdd_host

// file: test/tb_top.sv
// bench for the transmit descriptor decoder
`timescale 1ns/10ps

module tb_top;
    import tdd_pkg::*;
    logic         clk = 1'h0, rst_n = 1'h0, poll = 1'h0, tx_ready = 1'h1, stall = 1'h0;
    logic         fetch_req, fetch_valid, buf_req, buf_valid, buf_ready, tx_valid, tx_sof, tx_eof, wb_req, wb_ack;
    logic [7:0]   fetch_idx, wb_idx, buf_data, tx_data;
    logic [63:0]  buf_addr;
    logic [15:0]  buf_len;
    logic [31:0]  wb_word;
    tdd_desc_t    fetch_desc;
    tdd_offload_t offload, off_seen;
    logic [9:0]   got[$], exp_q[$];
    int           mismatches = 0, checks_done = 0, buf_reqs = 0;

    tdd_top #(.IDX_W(8)) u_tdd_top (
        .CLK_I(clk), .RST_N_I(rst_n), .POLL_I(poll), .FETCH_REQ_O(fetch_req), .FETCH_IDX_O(fetch_idx),
        .FETCH_VALID_I(fetch_valid), .FETCH_DESC_I(fetch_desc), .BUF_REQ_O(buf_req), .BUF_ADDR_O(buf_addr),
        .BUF_LEN_O(buf_len), .BUF_VALID_I(buf_valid), .BUF_DATA_I(buf_data), .BUF_READY_O(buf_ready),
        .TX_VALID_O(tx_valid), .TX_DATA_O(tx_data), .TX_SOF_O(tx_sof), .TX_EOF_O(tx_eof), .TX_READY_I(tx_ready),
        .OFFLOAD_O(offload), .WB_REQ_O(wb_req), .WB_IDX_O(wb_idx), .WB_WORD0_O(wb_word), .WB_ACK_I(wb_ack));
    tdd_host u_tdd_host (
        .clk_i(clk), .rst_n_i(rst_n), .fetch_req_i(fetch_req), .fetch_idx_i(fetch_idx), .fetch_desc_o(fetch_desc),
        .fetch_valid_o(fetch_valid), .buf_req_i(buf_req), .buf_addr_i(buf_addr), .buf_len_i(buf_len),
        .buf_ready_i(buf_ready), .buf_valid_o(buf_valid), .buf_data_o(buf_data), .wb_req_i(wb_req),
        .wb_idx_i(wb_idx), .wb_word_i(wb_word), .wb_ack_o(wb_ack));

    initial forever #12.5 clk = ~clk;
    always @(negedge clk) tx_ready <= !stall || !tx_ready;
    always @(posedge clk) begin
        if (buf_req) buf_reqs++;
        if (tx_valid && tx_ready) got.push_back({tx_sof, tx_eof, tx_data});
        if (tx_valid && tx_ready && tx_sof) off_seen <= offload;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic limit(input logic ok, input string what);
        chk(what, 1, ok);
        if (!ok) wrap_up();
    endtask
    task automatic add_seg(input logic [7:0] base, input int n, input logic sof, input logic eof);
        for (int k = 0; k < n; k++) exp_q.push_back({sof && k == 0, eof && k == n - 1, base + k[7:0]});
    endtask
    task automatic poll_at(input logic [7:0] idx);
        int i;
        poll = 1'h1;
        for (i = 0; i < 200 && !(fetch_req && fetch_idx === idx); i++) @(negedge clk);
        poll = 1'h0;
        limit(i < 200, "poll");
    endtask
    task automatic wait_done(input int n, input int idx);
        int i;
        for (i = 0; i < 2000 && (got.size() < n || u_tdd_host.wb_seen[idx] === 32'hffff_ffff); i++) @(negedge clk);
        limit(i < 2000, "frame done");
    endtask
    task automatic chk_stream;
        chk("tx count", exp_q.size(), got.size());
        foreach (exp_q[k]) chk("tx byte", exp_q[k], k < got.size() ? got[k] : 10'h3ff);
        exp_q.delete();
        got.delete();
    endtask

    // single segment frame with tag insertion, prompt host
    task automatic t_tagged_frame;
        u_tdd_host.ring[0] = {32'h0000_0001, 32'h1234_5640, 32'h0002_b5a7, 32'hb005_0010};
        add_seg(8'h40, 12, 1'h1, 1'h0);
        exp_q = {exp_q, 10'h081, 10'h000, 10'h0a7, 10'h0b5};
        add_seg(8'h4c, 4, 1'h0, 1'h1);
        poll_at(8'h00);
        wait_done(20, 0);
        chk_stream();
        chk("offload", 3'h5, off_seen);
        chk("status", 32'h3000_0000, u_tdd_host.wb_seen[0]);
    endtask
    // two segments, no tag, ring end, slow host and stalling sink
    task automatic t_split_frame;
        int i;
        u_tdd_host.slow = 2;
        stall = 1'h1;
        u_tdd_host.ring[1] = {32'h0, 32'h0000_0080, 32'h0000_0fff, 32'ha002_0005};
        u_tdd_host.ring[2] = {32'h8000_0000, 32'h0000_00c0, 32'h0, 32'hd000_0003};
        add_seg(8'h80, 5, 1'h1, 1'h0);
        add_seg(8'hc0, 3, 1'h0, 1'h1);
        poll_at(8'h01);
        wait_done(8, 2);
        chk_stream();
        chk("offload", 3'h2, off_seen);
        chk("status", 32'h2000_0000, u_tdd_host.wb_seen[1]);
        chk("status", 32'h5000_0000, u_tdd_host.wb_seen[2]);
        for (i = 0; i < 200 && !(fetch_valid && fetch_idx === 8'h00); i++) @(negedge clk);
        limit(i < 200, "wrap fetch");
        repeat (4) @(negedge clk);
        chk("buffer requests", 3, buf_reqs);
    endtask

    initial begin
        for (int k = 0; k < 8; k++) begin
            u_tdd_host.ring[k] = '0;
            u_tdd_host.wb_seen[k] = 32'hffff_ffff;
        end
        repeat (10) @(negedge clk);
        chk("reset outputs", 5'h00, {fetch_req, buf_req, buf_ready, tx_valid, wb_req});
        rst_n = 1'h1;
        t_tagged_frame();
        t_split_frame();
        wrap_up();
    end
endmodule // tb_top
